// ===== logic/serial_flash_spi_front_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_map.svh"
module serial_flash_spi_front_end (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Serial pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic io_line_0_in,
  input wire logic io_line_1_in,
  input wire logic io_line_2_in,
  input wire logic io_line_3_in,
  output logic io_line_0_out,
  output logic io_line_1_out,
  output logic io_line_2_out,
  output logic io_line_3_out,
  output logic io_line_0_oe_out,
  output logic io_line_1_oe_out,
  output logic io_line_2_oe_out,
  output logic io_line_3_oe_out,
  // Command decode from the core
  input wire flash_pkg::lane_mode_e lane_mode_in,
  input wire logic read_mode_in,
  input wire logic [1:0] addr_bytes_in,
  input wire flash_pkg::erase_scope_e erase_scope_in,
  // Read data source
  input wire logic [7:0] tx_byte_in,
  output logic tx_take_out,
  // Write data sink
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  // Protection and busy inputs
  input wire logic [3:0] block_protect_in,
  input wire logic status_lock_bit_in,
  input wire logic otp_lock_in,
  input wire logic busy_in,
  // Status outputs
  output logic selected_out,
  output logic [7:0] cmd_out,
  output logic cmd_valid_out,
  output logic [23:0] addr_out,
  output logic addr_valid_out,
  output logic [14:0] page_out,
  output logic [10:0] sector_out,
  output logic [6:0] block_out,
  output logic [23:0] erase_base_out,
  output logic frame_end_out,
  output logic overrun_out,
  output logic page_overflow_out,
  output logic status_write_blocked_out,
  output logic array_protect_out,
  output logic otp_write_blocked_out,
  output logic busy_out
);
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic [3:0] io_s1;
    logic [3:0] io_s2;
    logic armed;
    logic selected;
    flash_pkg::phase_e phase;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    logic [1:0] addr_left;
    logic [23:0] addr;
    logic [8:0] byte_cnt;
    logic [2:0] tx_cnt;
    logic [7:0] tx_sh;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic tx_take;
    logic [7:0] cmd;
    logic cmd_valid;
    logic addr_valid;
    logic [14:0] page;
    logic [10:0] sector;
    logic [6:0] block;
    logic [23:0] erase_base;
    logic pend_valid;
    logic [7:0] pend_data;
    logic out_valid;
    logic [7:0] out_data;
    logic frame_end;
    logic overrun;
    logic page_ovf;
    logic sr_blocked;
    logic arr_prot;
    logic otp_blocked;
    logic busy;
  } front_s;

  front_s st_reg;
  front_s st_next;

  byte_stream_if #(.WIDTH(`FL_BYTE_W)) fifo_wr ();
  byte_stream_if #(.WIDTH(`FL_BYTE_W)) fifo_rd ();

  byte_fifo #(
    .WIDTH(`FL_BYTE_W),
    .DEPTH(`FL_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .wr(fifo_wr),
    .rd(fifo_rd)
  );

  assign fifo_wr.valid = st_reg.pend_valid;
  assign fifo_wr.data = st_reg.pend_data;
  assign fifo_rd.ready = !st_reg.out_valid || rx_ready_in;

  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic byte_done;
  logic quad_now;
  flash_pkg::lane_mode_e lanes;
  logic [3:0] step;
  logic [3:0] bit_sum;
  logic [7:0] sh_new;
  logic [3:0] tx_sum;
  logic [7:0] tx_src;
  logic [23:0] addr_new;

  always_comb begin
    st_next = st_reg;
    st_next.tx_take = 1'b0;
    st_next.cmd_valid = 1'b0;
    st_next.addr_valid = 1'b0;
    st_next.frame_end = 1'b0;
    // Two-flop synchronisers; the second stage feeds logic, plus a third flop on sclk and cs for edge detection
    st_next.sclk_s1 = sclk_in;
    st_next.sclk_s2 = st_reg.sclk_s1;
    st_next.sclk_d = st_reg.sclk_s2;
    st_next.cs_s1 = cs_n_in;
    st_next.cs_s2 = st_reg.cs_s1;
    st_next.cs_d = st_reg.cs_s2;
    st_next.io_s1 = {io_line_3_in, io_line_2_in, io_line_1_in, io_line_0_in};
    st_next.io_s2 = st_reg.io_s1;
    rise = st_reg.sclk_s2 & ~st_reg.sclk_d;
    fall = ~st_reg.sclk_s2 & st_reg.sclk_d;
    cs_fall = ~st_reg.cs_s2 & st_reg.cs_d;
    cs_rise = st_reg.cs_s2 & ~st_reg.cs_d;
    // Instruction byte always on one lane
    lanes = (st_reg.phase == flash_pkg::PH_CMD) ? flash_pkg::LANE_SINGLE
                                                : lane_mode_in;
    case (lanes)
      flash_pkg::LANE_DUAL: step = 4'h2;
      flash_pkg::LANE_QUAD: step = 4'h4;
      default: step = 4'h1;
    endcase
    quad_now = (lane_mode_in == flash_pkg::LANE_QUAD);
    // Shift-in per lane width, MSB first
    case (lanes)
      flash_pkg::LANE_DUAL: sh_new = {st_reg.sh[5:0], st_reg.io_s2[1:0]};
      flash_pkg::LANE_QUAD: sh_new = {st_reg.sh[3:0], st_reg.io_s2};
      default: sh_new = {st_reg.sh[6:0], st_reg.io_s2[0]};
    endcase
    bit_sum = {1'b0, st_reg.bit_cnt} + step;
    byte_done = bit_sum[3];
    addr_new = {st_reg.addr[15:0], sh_new};
    tx_src = (st_reg.tx_cnt == 3'h0) ? tx_byte_in : st_reg.tx_sh;
    tx_sum = {1'b0, st_reg.tx_cnt} + step;

    // Power-up gate: a selection counts only after chip select was high
    if (st_reg.cs_s2) begin
      st_next.armed = 1'b1;
    end
    if (cs_fall && st_reg.armed) begin
      st_next.selected = 1'b1;
    end

    if (st_reg.pend_valid && fifo_wr.ready) begin
      st_next.pend_valid = 1'b0;
    end
    if (st_reg.selected && rise) begin
      st_next.sh = sh_new;
      st_next.bit_cnt = bit_sum[2:0];
      if (byte_done) begin
        case (st_reg.phase)
          flash_pkg::PH_CMD: begin
            st_next.cmd = sh_new;
            st_next.cmd_valid = 1'b1;
            st_next.byte_cnt = '0;
            st_next.addr_left = addr_bytes_in;
            st_next.phase = (addr_bytes_in == 2'h0) ? flash_pkg::PH_DATA
                                                    : flash_pkg::PH_ADDR;
          end
          flash_pkg::PH_ADDR: begin
            st_next.addr = addr_new;
            st_next.addr_left = st_reg.addr_left - 2'h1;
            if (st_reg.addr_left == 2'h1) begin
              st_next.phase = flash_pkg::PH_DATA;
              st_next.addr_valid = 1'b1;
              st_next.page = addr_new[`FL_PAGE_MSB:`FL_PAGE_LSB];
              st_next.sector = addr_new[`FL_SECTOR_MSB:`FL_SECTOR_LSB];
              st_next.block = addr_new[`FL_BLOCK_MSB:`FL_BLOCK_LSB];
              // Erase granules are sector, block or chip; never a page
              case (erase_scope_in)
                flash_pkg::ER_CHIP: st_next.erase_base = '0;
                flash_pkg::ER_BLOCK: begin
                  st_next.erase_base = addr_new;
                  st_next.erase_base[`FL_BLOCK_LSB-1:0] = '0;
                end
                default: begin
                  st_next.erase_base = addr_new;
                  st_next.erase_base[`FL_SECTOR_LSB-1:0] = '0;
                end
              endcase
              st_next.otp_blocked = otp_lock_in &&
                (addr_new < `FL_OTP_BYTES);
            end
          end
          default: begin
            if (!read_mode_in) begin
              // One page at most per program operation
              if (st_reg.byte_cnt == `FL_PAGE_BYTES) begin
                st_next.page_ovf = 1'b1;
              end else if (st_reg.pend_valid && !fifo_wr.ready) begin
                st_next.overrun = 1'b1;
              end else begin
                st_next.pend_valid = 1'b1;
                st_next.pend_data = sh_new;
                st_next.byte_cnt = st_reg.byte_cnt + 9'h1;
              end
            end
          end
        endcase
      end
    end

    // Read data changes on falling edges, lanes per mode
    if (st_reg.selected && fall && st_reg.phase == flash_pkg::PH_DATA &&
        read_mode_in) begin
      st_next.tx_cnt = tx_sum[2:0];
      st_next.tx_take = (st_reg.tx_cnt == 3'h0);
      case (lanes)
        flash_pkg::LANE_DUAL: begin
          st_next.io_out = {2'h0, tx_src[7:6]};
          st_next.io_oe = 4'h3;
          st_next.tx_sh = {tx_src[5:0], 2'h0};
        end
        flash_pkg::LANE_QUAD: begin
          st_next.io_out = tx_src[7:4];
          st_next.io_oe = 4'hf;
          st_next.tx_sh = {tx_src[3:0], 4'h0};
        end
        default: begin
          st_next.io_out = {2'h0, tx_src[7], 1'b0};
          st_next.io_oe = 4'h2;
          st_next.tx_sh = {tx_src[6:0], 1'b0};
        end
      endcase
    end

    if (fifo_rd.valid && fifo_rd.ready) begin
      st_next.out_valid = 1'b1;
      st_next.out_data = fifo_rd.data;
    end else if (rx_ready_in) begin
      st_next.out_valid = 1'b0;
    end

    // Deselect ends the instruction and floats all lines
    if (st_reg.cs_s2) begin
      st_next.io_oe = 4'h0;
      st_next.selected = 1'b0;
      st_next.phase = flash_pkg::PH_CMD;
      st_next.bit_cnt = '0;
      st_next.tx_cnt = '0;
      st_next.byte_cnt = '0;
      st_next.addr_left = '0;
    end
    if (cs_rise && st_reg.selected) begin
      st_next.frame_end = 1'b1;
    end

    // Protect pin is live only outside quad mode
    st_next.sr_blocked = !quad_now && !st_reg.io_s2[2] &&
                         status_lock_bit_in;
    st_next.arr_prot = !quad_now && !st_reg.io_s2[2] &&
                       status_lock_bit_in && (block_protect_in != 4'h0);
    // Internal operation keeps running whatever chip select does
    st_next.busy = busy_in;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.sclk_s1 <= 1'b0;
      st_reg.cs_s1 <= 1'b0;
      st_reg.phase <= flash_pkg::PH_CMD;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end

  assign io_line_0_out = st_reg.io_out[0];
  assign io_line_1_out = st_reg.io_out[1];
  assign io_line_2_out = st_reg.io_out[2];
  assign io_line_3_out = st_reg.io_out[3];
  assign io_line_0_oe_out = st_reg.io_oe[0];
  assign io_line_1_oe_out = st_reg.io_oe[1];
  assign io_line_2_oe_out = st_reg.io_oe[2];
  assign io_line_3_oe_out = st_reg.io_oe[3];
  assign tx_take_out = st_reg.tx_take;
  assign rx_data_out = st_reg.out_data;
  assign rx_valid_out = st_reg.out_valid;
  assign selected_out = st_reg.selected;
  assign cmd_out = st_reg.cmd;
  assign cmd_valid_out = st_reg.cmd_valid;
  assign addr_out = st_reg.addr;
  assign addr_valid_out = st_reg.addr_valid;
  assign page_out = st_reg.page;
  assign sector_out = st_reg.sector;
  assign block_out = st_reg.block;
  assign erase_base_out = st_reg.erase_base;
  assign frame_end_out = st_reg.frame_end;
  assign overrun_out = st_reg.overrun;
  assign page_overflow_out = st_reg.page_ovf;
  assign status_write_blocked_out = st_reg.sr_blocked;
  assign array_protect_out = st_reg.arr_prot;
  assign otp_write_blocked_out = st_reg.otp_blocked;
  assign busy_out = st_reg.busy;
endmodule : serial_flash_spi_front_end
`default_nettype wire

// ===== logic/flash_map.svh
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH
`define FL_ADDR_W 24
`define FL_PAGE_LSB 8
`define FL_PAGE_MSB 22
`define FL_SECTOR_LSB 12
`define FL_SECTOR_MSB 22
`define FL_BLOCK_LSB 16
`define FL_BLOCK_MSB 22
`define FL_PAGE_BYTES 9'h100
`define FL_OTP_BYTES 24'h000200
`define FL_FIFO_DEPTH 8
`define FL_BYTE_W 8
`endif

// ===== logic/flash_pkg.sv
`default_nettype none
package flash_pkg;
  typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} lane_mode_e;
  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA} phase_e;
  typedef enum logic [1:0] {ER_SECTOR, ER_BLOCK, ER_CHIP} erase_scope_e;
endpackage : flash_pkg
`default_nettype wire

// ===== logic/byte_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// ===== logic/byte_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Streams
  byte_stream_if.snk wr,
  byte_stream_if.src rd
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
  } fifo_s;
  fifo_s st_reg;
  fifo_s st_next;
  logic do_wr;
  logic do_rd;

  assign wr.ready = (st_reg.count != PW'(0) + (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign rd.valid = (st_reg.count != '0);
  assign rd.data = st_reg.mem[st_reg.rptr];

  always_comb begin
    st_next = st_reg;
    do_wr = wr.valid & wr.ready;
    do_rd = rd.valid & rd.ready;
    if (do_wr) begin
      st_next.mem[st_reg.wptr] = wr.data;
      st_next.wptr = (st_reg.wptr == PW'(DEPTH - 1)) ? '0 : st_reg.wptr + 1'b1;
    end
    if (do_rd) begin
      st_next.rptr = (st_reg.rptr == PW'(DEPTH - 1)) ? '0 : st_reg.rptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (do_rd && !do_wr) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else if (ce_in) begin
      st_reg <= st_next;
    end
  end
endmodule : byte_fifo
`default_nettype wire

// ===== verif/flash_fe_chk.sv
`timescale 1ns/1ps
`default_nettype none
module flash_fe_chk (
  // Clock, reset and inputs
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic io_line_2_in,
  input wire flash_pkg::lane_mode_e lane_mode_in,
  input wire flash_pkg::erase_scope_e erase_scope_in,
  input wire logic [3:0] block_protect_in,
  input wire logic status_lock_bit_in,
  input wire logic otp_lock_in,
  input wire logic busy_in,
  // Outputs
  input wire logic io_line_1_out,
  input wire logic io_line_0_oe_out,
  input wire logic io_line_1_oe_out,
  input wire logic io_line_2_oe_out,
  input wire logic io_line_3_oe_out,
  input wire logic selected_out,
  input wire logic cmd_valid_out,
  input wire logic [23:0] addr_out,
  input wire logic addr_valid_out,
  input wire logic [14:0] page_out,
  input wire logic [10:0] sector_out,
  input wire logic [6:0] block_out,
  input wire logic [23:0] erase_base_out,
  input wire logic frame_end_out,
  input wire logic page_overflow_out,
  input wire logic status_write_blocked_out,
  input wire logic array_protect_out,
  input wire logic otp_write_blocked_out,
  input wire logic busy_out
);
  logic oe_any;
  logic wp_on;
  logic quad;
  logic [23:0] base_exp;
  assign oe_any = |{io_line_3_oe_out, io_line_2_oe_out, io_line_1_oe_out,
                    io_line_0_oe_out};
  assign quad = lane_mode_in == flash_pkg::LANE_QUAD;
  assign wp_on = ce_in && !quad && !io_line_2_in && status_lock_bit_in;
  assign base_exp = (erase_scope_in == flash_pkg::ER_CHIP) ? 24'h000000 :
    (erase_scope_in == flash_pkg::ER_BLOCK) ? {addr_out[23:16], 16'h0000} :
    {addr_out[23:12], 12'h000};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  a_float_deselect: assert property (cs_n_in [*5] |-> !oe_any)
    else $error("Data line driven while deselected");
  a_drive_on_fall: assert property (io_line_1_oe_out &&
    $past(io_line_1_oe_out) && $changed(io_line_1_out) |-> !sclk_in)
    else $error("Output bit changed outside clock low phase");
  a_wp_status_lock: assert property (wp_on [*5] |->
    status_write_blocked_out)
    else $error("Status write not blocked");
  a_wp_array_guard: assert property ((wp_on && block_protect_in != 4'h0)
    [*5] |-> array_protect_out)
    else $error("Array not protected");
  a_quad_ignores_wp: assert property ((ce_in && quad) [*5] |->
    !status_write_blocked_out && !array_protect_out)
    else $error("Protect active in quad mode");
  a_busy_follows: assert property (ce_in |=> busy_out == $past(busy_in))
    else $error("Busy not carried through");
  a_addr_map: assert property (addr_valid_out |=>
    page_out == addr_out[22:8] && sector_out == addr_out[22:12] &&
    block_out == addr_out[22:16])
    else $error("Page, sector or block number wrong");
  a_erase_base: assert property (addr_valid_out |=>
    erase_base_out == $past(base_exp))
    else $error("Erase base wrong");
  a_otp_guard: assert property (addr_valid_out |=>
    otp_write_blocked_out == ($past(otp_lock_in) && addr_out < 24'h000200))
    else $error("Security sector lock wrong");
  a_page_sticky: assert property (page_overflow_out |=> page_overflow_out)
    else $error("Page overflow flag lost");
  a_cmd_selected: assert property (cmd_valid_out |->
    selected_out && !cs_n_in)
    else $error("Instruction taken while not selected");
  a_frame_end: assert property ($rose(cs_n_in) && selected_out |->
    ##[1:5] frame_end_out)
    else $error("No frame end after deselect");
endmodule : flash_fe_chk
bind serial_flash_spi_front_end flash_fe_chk chk (
  .clk_in, .rst_in, .ce_in, .cs_n_in, .sclk_in, .io_line_2_in,
  .lane_mode_in, .erase_scope_in, .block_protect_in, .status_lock_bit_in,
  .otp_lock_in, .busy_in, .io_line_1_out, .io_line_0_oe_out,
  .io_line_1_oe_out, .io_line_2_oe_out, .io_line_3_oe_out, .selected_out,
  .cmd_valid_out, .addr_out, .addr_valid_out, .page_out, .sector_out,
  .block_out, .erase_base_out, .frame_end_out, .page_overflow_out,
  .status_write_blocked_out, .array_protect_out, .otp_write_blocked_out,
  .busy_out);
`default_nettype wire

// ===== verif/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  input wire logic [3:0] io_in
);
  // 8 MHz link clock, well inside every lane limit
  localparam realtime HALF = 62.5;
  logic cpol;
  initial begin
    cpol = 1'b0;
    sclk_out = 1'b0;
    cs_n_out = 1'b0;
    io_out = 4'h0;
    io_oe_out = 4'h0;
  end
  function automatic logic [3:0] lanes(input int n);
    return (n == 1) ? 4'h1 : (n == 2) ? 4'h3 : 4'hf;
  endfunction : lanes
  task automatic sel(input logic on);
    #(HALF);
    cs_n_out = !on;
    io_oe_out = 4'h0;
    #(HALF);
  endtask : sel
  // Idle clock level: low for mode 0, high for mode 3; call while deselected
  task automatic set_mode(input logic p);
    #(HALF);
    cpol = p;
    sclk_out = p;
    #(HALF);
  endtask : set_mode
  // Data set after the falling edge, taken on the rise
  task automatic send(input logic [7:0] b, input int n);
    for (int i = 8 - n; i >= 0; i -= n) begin
      if (cpol) sclk_out = 1'b0;
      io_oe_out = lanes(n);
      io_out = 4'(b >> i) & lanes(n);
      #(HALF);
      sclk_out = 1'b1;
      #(HALF);
      if (!cpol) sclk_out = 1'b0;
    end
  endtask : send
  task automatic recv(output logic [7:0] b, input int n);
    io_oe_out = 4'h0;
    b = 8'h00;
    for (int i = 0; i < 8; i += n) begin
      if (cpol) sclk_out = 1'b0;
      #(HALF);
      sclk_out = 1'b1;
      b = (n == 1) ? {b[6:0], io_in[1]} : (b << n) | 8'(io_in & lanes(n));
      #(HALF);
      if (!cpol) sclk_out = 1'b0;
    end
  endtask : recv
endmodule : spi_host_model
`default_nettype wire

// ===== verif/serial_flash_spi_front_end_tb.sv
`timescale 1ns/1ps
`default_nettype none
module serial_flash_spi_front_end_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic read_mode_in = 1'b0;
  logic rx_ready_in = 1'b1;
  logic status_lock_bit_in = 1'b0;
  logic otp_lock_in = 1'b0;
  logic busy_in = 1'b0;
  logic wp_n = 1'b1;
  logic [1:0] addr_bytes_in = 2'h3;
  logic [7:0] tx_byte_in = 8'h00;
  logic [3:0] block_protect_in = 4'h0;
  flash_pkg::lane_mode_e lane_mode_in = flash_pkg::LANE_SINGLE;
  flash_pkg::erase_scope_e erase_scope_in = flash_pkg::ER_SECTOR;
  wire logic sclk_in;
  wire logic cs_n_in;
  wire logic [3:0] h_io;
  wire logic [3:0] h_oe;
  wire logic [3:0] pin;
  logic io_line_0_out, io_line_1_out, io_line_2_out, io_line_3_out;
  logic io_line_0_oe_out, io_line_1_oe_out, io_line_2_oe_out;
  logic io_line_3_oe_out, tx_take_out, rx_valid_out, selected_out;
  logic cmd_valid_out, addr_valid_out, frame_end_out, overrun_out;
  logic page_overflow_out, status_write_blocked_out, array_protect_out;
  logic otp_write_blocked_out, busy_out;
  logic [7:0] rx_data_out, cmd_out;
  logic [23:0] addr_out, erase_base_out;
  logic [14:0] page_out;
  logic [10:0] sector_out;
  logic [6:0] block_out;
  logic [3:0] d_io, d_oe;
  logic [7:0] rxq[$];
  int err_total = 0;
  int n_checks = 0;
  int n_cmd = 0;
  int n_fe = 0;
  int n_tk = 0;
  assign d_io = {io_line_3_out, io_line_2_out, io_line_1_out, io_line_0_out};
  assign d_oe = {io_line_3_oe_out, io_line_2_oe_out, io_line_1_oe_out,
                 io_line_0_oe_out};
  // Released lines rest at their pull level; line 2 carries wp_n
  assign pin = (d_oe & d_io) | (~d_oe & h_oe & h_io) |
               (~d_oe & ~h_oe & {1'b1, wp_n, 2'b11});
  spi_host_model host (.sclk_out(sclk_in), .cs_n_out(cs_n_in),
    .io_out(h_io), .io_oe_out(h_oe), .io_in(pin));
  serial_flash_spi_front_end dut (.clk_in, .rst_in, .ce_in, .sclk_in,
    .cs_n_in, .io_line_0_in(pin[0]), .io_line_1_in(pin[1]),
    .io_line_2_in(pin[2]), .io_line_3_in(pin[3]), .io_line_0_out,
    .io_line_1_out, .io_line_2_out, .io_line_3_out, .io_line_0_oe_out,
    .io_line_1_oe_out, .io_line_2_oe_out, .io_line_3_oe_out, .lane_mode_in,
    .read_mode_in, .addr_bytes_in, .erase_scope_in, .tx_byte_in,
    .tx_take_out, .rx_data_out, .rx_valid_out, .rx_ready_in,
    .block_protect_in, .status_lock_bit_in, .otp_lock_in, .busy_in,
    .selected_out, .cmd_out, .cmd_valid_out, .addr_out, .addr_valid_out,
    .page_out, .sector_out, .block_out, .erase_base_out, .frame_end_out,
    .overrun_out, .page_overflow_out, .status_write_blocked_out,
    .array_protect_out, .otp_write_blocked_out, .busy_out);
  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (rx_valid_out === 1'b1 && rx_ready_in) rxq.push_back(rx_data_out);
    if (cmd_valid_out === 1'b1) n_cmd++;
    if (frame_end_out === 1'b1) n_fe++;
    if (tx_take_out === 1'b1) n_tk++;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic clks(input int n);
    repeat (n) @(posedge clk_in);
  endtask : clks
  task automatic frame(input logic [7:0] c, input logic [23:0] a, int n);
    host.sel(1'b1);
    host.send(c, 1);
    for (int i = 16; i >= 0; i -= 8) host.send(a[i+:8], n);
  endtask : frame
  task automatic t_arm;
    host.send(8'h9f, 1);
    clks(5);
    chk(24'(n_cmd), 24'h0);
    chk(24'(selected_out), 24'h0);
    host.sel(1'b0);
  endtask : t_arm
  task automatic t_read;
    logic [7:0] b;
    int fe0;
    int tk0;
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_in);
      lane_mode_in <= flash_pkg::lane_mode_e'(m);
      erase_scope_in <= flash_pkg::erase_scope_e'(m);
      read_mode_in <= 1'b1;
      tx_byte_in <= 8'h96 + 8'(m);
      fe0 = n_fe;
      tk0 = n_tk;
      frame(8'h0b, 24'h7ef123, 1 << m);
      host.recv(b, 1 << m);
      chk(24'(b), 24'(8'h96 + 8'(m)));
      chk(24'(cmd_out), 24'h00000b);
      chk(addr_out, 24'h7ef123);
      chk(24'(page_out), 24'h007ef1);
      chk(24'(sector_out), 24'h0007ef);
      chk(24'(block_out), 24'h00007e);
      chk(erase_base_out, m == 0 ? 24'h7ef000 :
          m == 1 ? 24'h7e0000 : 24'h0);
      host.sel(1'b0);
      clks(5);
      chk(24'(d_oe), 24'h0);
      chk(24'(n_fe - fe0), 24'h1);
      chk(24'(n_tk - tk0), 24'h2);
    end
  endtask : t_read
  task automatic t_write;
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_in);
      lane_mode_in <= flash_pkg::lane_mode_e'(m);
      read_mode_in <= 1'b0;
      otp_lock_in <= 1'b1;
      busy_in <= 1'b1;
      wp_n <= 1'b0;
      status_lock_bit_in <= 1'b1;
      block_protect_in <= 4'h3;
      rxq.delete();
      frame(8'h02, m == 0 ? 24'h0001ff : 24'h000200, 1 << m);
      chk(24'(otp_write_blocked_out), 24'(m == 0));
      for (int i = 0; i < 3; i++) host.send(8'h3c ^ 8'(i), 1 << m);
      host.sel(1'b0);
      clks(8);
      chk(24'(busy_out), 24'h1);
      chk(24'(status_write_blocked_out), 24'(m != 2));
      chk(24'(array_protect_out), 24'(m != 2));
      chk(24'(rxq.size()), 24'h3);
      for (int i = 0; i < 3; i++) chk(24'(rxq[i]), 24'(8'h3c ^ 8'(i)));
    end
    @(posedge clk_in);
    busy_in <= 1'b0;
    wp_n <= 1'b1;
  endtask : t_write
  task automatic t_fifo;
    @(posedge clk_in);
    rx_ready_in <= 1'b0;
    rxq.delete();
    frame(8'h02, 24'h010000, 4);
    for (int i = 0; i < 16; i++) host.send(8'(i), 4);
    host.sel(1'b0);
    chk(24'(overrun_out), 24'h1);
    @(posedge clk_in);
    rx_ready_in <= 1'b1;
    clks(40);
    for (int i = 0; i < 8; i++) chk(24'(rxq[i]), 24'(i));
  endtask : t_fifo
  task automatic t_page;
    rxq.delete();
    frame(8'h02, 24'h020000, 4);
    for (int i = 0; i < 256; i++) host.send(8'(i), 4);
    clks(8);
    chk(24'(page_overflow_out), 24'h0);
    host.send(8'hee, 4);
    clks(8);
    chk(24'(page_overflow_out), 24'h1);
    host.sel(1'b0);
    clks(20);
    chk(24'(rxq.size()), 24'h000100);
  endtask : t_page
  // Mode 3 read with no address bytes, then a clock-enable freeze
  task automatic t_mode3;
    logic [7:0] b;
    @(posedge clk_in);
    lane_mode_in <= flash_pkg::LANE_SINGLE;
    addr_bytes_in <= 2'h0;
    read_mode_in <= 1'b1;
    tx_byte_in <= 8'h5a;
    host.set_mode(1'b1);
    host.sel(1'b1);
    host.send(8'h05, 1);
    host.recv(b, 1);
    chk(24'(b), 24'h00005a);
    chk(24'(cmd_out), 24'h000005);
    host.sel(1'b0);
    @(posedge clk_in);
    ce_in <= 1'b0;
    busy_in <= 1'b1;
    clks(6);
    chk(24'(busy_out), 24'h0);
    ce_in <= 1'b1;
    clks(3);
    chk(24'(busy_out), 24'h1);
  endtask : t_mode3
  initial begin
    clks(5);
    rst_in <= 1'b0;
    clks(2);
    t_arm();
    t_read();
    t_write();
    t_fifo();
    t_page();
    t_mode3();
    finish_test();
  end
  initial begin
    #400000;
    err_total++;
    finish_test();
  end
endmodule : serial_flash_spi_front_end_tb
`default_nettype wire
